// file: psim_input_map.v
`timescale 1ns/1ps
`include "psim_regs.vh"


module psim_input_map (
    input wire clk_i,                        // System clock, 200 MHz
    input wire nrst_i,                       // Async reset, active low
    input wire [`PSIM_ADDR_W-1:0] addr_i,    // Register word address
    input wire [`PSIM_DATA_W-1:0] wdata_i,   // Register write data
    input wire wr_i,                         // Write strobe
    input wire rd_i,                         // Read strobe
    output wire [`PSIM_DATA_W-1:0] rdata_o,  // Read data, cycle after rd
    input wire [`PSIM_NUM_PINS-1:0] pins_i,  // Remappable pin levels
    output wire ext_irq_one_o,               // External interrupt 1 in
    output wire ext_irq_two_o,               // External interrupt 2 in
    output wire ext_irq_three_o,             // External interrupt 3 in
    output wire ext_irq_four_o,              // External interrupt 4 in
    output wire tmr_two_clk_o,               // Timer 2 external clock
    output wire tmr_three_clk_o,             // Timer 3 external clock
    output wire tmr_four_clk_o,              // Timer 4 external clock
    output wire tmr_five_clk_o,              // Timer 5 external clock
    output wire [7:0] capture_o,             // Input captures 8..1
    output wire pin_map_lock_o               // Current lock state
);

    // ------------------------------------------------------------------
    // Unlock sequencer states
    // ------------------------------------------------------------------
    localparam [1:0] ST_IDLE = 2'b00;   // Waiting for first key
    localparam [1:0] ST_KEY1 = 2'b01;   // First key seen
    localparam [1:0] ST_ARMED = 2'b10;  // Both keys seen

    // ------------------------------------------------------------------
    // Selector slot numbering inside the flat selector vector
    // ------------------------------------------------------------------
    localparam integer S_IRQ1 = 0;
    localparam integer S_IRQ2 = 1;
    localparam integer S_IRQ3 = 2;
    localparam integer S_IRQ4 = 3;
    localparam integer S_TMR2 = 4;
    localparam integer S_TMR3 = 5;
    localparam integer S_TMR4 = 6;
    localparam integer S_TMR5 = 7;
    localparam integer S_CAP1 = 8;
    // Captures 2 to 8 follow in slots 9 to 15, in capture order

    localparam integer SW = `PSIM_SEL_W;
    localparam integer NSEL = `PSIM_NUM_SEL;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    reg [SW*NSEL-1:0] sel_r;            // All sixteen selector fields
    reg [SW*NSEL-1:0] sel_nxt;          // Next selector values
    reg lock_r;                         // Mapping lock bit
    reg lock_nxt;                       // Next lock value
    reg [1:0] seq_r;                    // Unlock sequencer state
    reg [1:0] seq_nxt;                  // Next sequencer state
    reg [`PSIM_DATA_W-1:0] rdata_r;     // Registered read data
    reg [`PSIM_DATA_W-1:0] rdata_nxt;   // Read mux result
    reg [NSEL-1:0] periph_r;            // Registered peripheral inputs
    wire [NSEL-1:0] pick;               // Combinational pin picks
    wire map_we;                        // Map write permitted
    wire osc_wr;                        // Write to oscillator control
    wire [7:0] osc_low;                 // Low byte of that write

    // Permission is checked against the lock as it stands this cycle.
    // A refused write still ends normally on the bus; only the store
    // is skipped, so a stray store cannot corrupt a locked map.
    assign map_we = wr_i & ~lock_r;
    assign osc_wr = wr_i & (addr_i == `PSIM_ADDR_OSC_CTRL);
    assign osc_low = wdata_i[7:0];

    // ------------------------------------------------------------------
    // Helpers for field access
    // ------------------------------------------------------------------

    // Fetch one selector field from the flat vector
    function [SW-1:0] get_sel;
        input [SW*NSEL-1:0] vec;
        input integer slot;
        begin
            get_sel = vec[slot*SW +: SW];
        end
    endfunction

    // Pack a high and low selector into a 16-bit register image
    function [`PSIM_DATA_W-1:0] pack2;
        input [SW-1:0] hi;
        input [SW-1:0] lo;
        begin
            pack2 = {`PSIM_DATA_W{1'b0}};
            pack2[`PSIM_SEL_HI_LSB +: SW] = hi;
            pack2[`PSIM_SEL_LO_LSB +: SW] = lo;
        end
    endfunction

    // ------------------------------------------------------------------
    // Map register writes
    // ------------------------------------------------------------------

    // Only the selector bits are stored; everything else is dropped.
    // The control address falls to the default branch: the lock bit
    // belongs to the sequencer and is never a map store.
    always @* begin
        sel_nxt = sel_r;
        if (map_we) begin
            case (addr_i)
                `PSIM_ADDR_IRQ1: begin
                    sel_nxt[S_IRQ1*SW +: SW] =
                        wdata_i[`PSIM_SEL_HI_LSB +: SW];
                end
                `PSIM_ADDR_IRQ3_IRQ2: begin
                    sel_nxt[S_IRQ3*SW +: SW] =
                        wdata_i[`PSIM_SEL_HI_LSB +: SW];
                    sel_nxt[S_IRQ2*SW +: SW] =
                        wdata_i[`PSIM_SEL_LO_LSB +: SW];
                end
                `PSIM_ADDR_IRQ4: begin
                    sel_nxt[S_IRQ4*SW +: SW] =
                        wdata_i[`PSIM_SEL_LO_LSB +: SW];
                end
                `PSIM_ADDR_TMR3_TMR2: begin
                    sel_nxt[S_TMR3*SW +: SW] =
                        wdata_i[`PSIM_SEL_HI_LSB +: SW];
                    sel_nxt[S_TMR2*SW +: SW] =
                        wdata_i[`PSIM_SEL_LO_LSB +: SW];
                end
                `PSIM_ADDR_TMR5_TMR4: begin
                    sel_nxt[S_TMR5*SW +: SW] =
                        wdata_i[`PSIM_SEL_HI_LSB +: SW];
                    sel_nxt[S_TMR4*SW +: SW] =
                        wdata_i[`PSIM_SEL_LO_LSB +: SW];
                end
                `PSIM_ADDR_CAP2_CAP1: begin
                    sel_nxt[(S_CAP1+1)*SW +: SW] =
                        wdata_i[`PSIM_SEL_HI_LSB +: SW];
                    sel_nxt[S_CAP1*SW +: SW] =
                        wdata_i[`PSIM_SEL_LO_LSB +: SW];
                end
                `PSIM_ADDR_CAP4_CAP3: begin
                    sel_nxt[(S_CAP1+3)*SW +: SW] =
                        wdata_i[`PSIM_SEL_HI_LSB +: SW];
                    sel_nxt[(S_CAP1+2)*SW +: SW] =
                        wdata_i[`PSIM_SEL_LO_LSB +: SW];
                end
                `PSIM_ADDR_CAP6_CAP5: begin
                    sel_nxt[(S_CAP1+5)*SW +: SW] =
                        wdata_i[`PSIM_SEL_HI_LSB +: SW];
                    sel_nxt[(S_CAP1+4)*SW +: SW] =
                        wdata_i[`PSIM_SEL_LO_LSB +: SW];
                end
                `PSIM_ADDR_CAP8_CAP7: begin
                    sel_nxt[(S_CAP1+7)*SW +: SW] =
                        wdata_i[`PSIM_SEL_HI_LSB +: SW];
                    sel_nxt[(S_CAP1+6)*SW +: SW] =
                        wdata_i[`PSIM_SEL_LO_LSB +: SW];
                end
                default: begin
                    // Other addresses hold no selector
                    sel_nxt = sel_r;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Lock unlock sequencer
    // ------------------------------------------------------------------

    // Two key writes to the oscillator control low byte arm the lock.
    // The key bytes both carry bit 6 set, so they must never touch the
    // lock themselves; only the write after the keys does.
    // Any write elsewhere breaks the sequence, which keeps a stray
    // store from leaving the lock armed for later code.
    // Reads in between leave the sequence where it was.
    always @* begin
        seq_nxt = seq_r;
        lock_nxt = lock_r;
        if (wr_i && !osc_wr) begin
            seq_nxt = ST_IDLE;
        end else if (osc_wr) begin
            case (seq_r)
                ST_IDLE: begin
                    if (osc_low == `PSIM_KEY_FIRST) begin
                        seq_nxt = ST_KEY1;
                    end
                end
                ST_KEY1: begin
                    if (osc_low == `PSIM_KEY_SECOND) begin
                        seq_nxt = ST_ARMED;
                    end else if (osc_low == `PSIM_KEY_FIRST) begin
                        // Repeated first key restarts cleanly
                        seq_nxt = ST_KEY1;
                    end else begin
                        seq_nxt = ST_IDLE;
                    end
                end
                ST_ARMED: begin
                    // Single operation sets or clears the lock
                    lock_nxt = wdata_i[`PSIM_LOCK_BIT];
                    seq_nxt = ST_IDLE;
                end
                default: begin
                    seq_nxt = ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------------

    // Data is driven only in the cycle after a read strobe, else zero.
    // Reads ignore the lock, so a locked map can still be inspected.
    always @* begin
        rdata_nxt = {`PSIM_DATA_W{1'b0}};
        if (rd_i) begin
            case (addr_i)
                `PSIM_ADDR_IRQ1: begin
                    rdata_nxt = pack2(get_sel(sel_r, S_IRQ1), {SW{1'b0}});
                end
                `PSIM_ADDR_IRQ3_IRQ2: begin
                    rdata_nxt = pack2(get_sel(sel_r, S_IRQ3),
                                      get_sel(sel_r, S_IRQ2));
                end
                `PSIM_ADDR_IRQ4: begin
                    rdata_nxt = pack2({SW{1'b0}}, get_sel(sel_r, S_IRQ4));
                end
                `PSIM_ADDR_TMR3_TMR2: begin
                    rdata_nxt = pack2(get_sel(sel_r, S_TMR3),
                                      get_sel(sel_r, S_TMR2));
                end
                `PSIM_ADDR_TMR5_TMR4: begin
                    rdata_nxt = pack2(get_sel(sel_r, S_TMR5),
                                      get_sel(sel_r, S_TMR4));
                end
                `PSIM_ADDR_CAP2_CAP1: begin
                    rdata_nxt = pack2(get_sel(sel_r, S_CAP1 + 1),
                                      get_sel(sel_r, S_CAP1));
                end
                `PSIM_ADDR_CAP4_CAP3: begin
                    rdata_nxt = pack2(get_sel(sel_r, S_CAP1 + 3),
                                      get_sel(sel_r, S_CAP1 + 2));
                end
                `PSIM_ADDR_CAP6_CAP5: begin
                    rdata_nxt = pack2(get_sel(sel_r, S_CAP1 + 5),
                                      get_sel(sel_r, S_CAP1 + 4));
                end
                `PSIM_ADDR_CAP8_CAP7: begin
                    rdata_nxt = pack2(get_sel(sel_r, S_CAP1 + 7),
                                      get_sel(sel_r, S_CAP1 + 6));
                end
                `PSIM_ADDR_OSC_CTRL: begin
                    // Only the lock bit lives here; the rest reads zero
                    rdata_nxt[`PSIM_LOCK_BIT] = lock_r;
                end
                default: begin
                    // Unmapped addresses answer zero
                    rdata_nxt = {`PSIM_DATA_W{1'b0}};
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Pin selection, one picker per peripheral input
    // ------------------------------------------------------------------

    // Invalid numbers, including the reset value 63, give ground.
    // One picker per input costs area over a shared mux, but keeps
    // each input free of the timing of the others.
    genvar g;
    generate
        for (g = 0; g < NSEL; g = g + 1) begin : g_pick
            psim_pin_pick u_pick (
                .sel_i  (sel_r[g*SW +: SW]),
                .pins_i (pins_i),
                .pick_o (pick[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------

    // All state; outputs are taken from these flops only. The pin path
    // costs one cycle of latency, traded for clean flop-driven outputs.
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sel_r <= {NSEL{`PSIM_SEL_RST}};
            lock_r <= `PSIM_LOCK_RST;
            seq_r <= ST_IDLE;
            rdata_r <= {`PSIM_DATA_W{1'b0}};
            periph_r <= {NSEL{1'b0}};
        end else begin
            sel_r <= sel_nxt;
            lock_r <= lock_nxt;
            seq_r <= seq_nxt;
            rdata_r <= rdata_nxt;
            periph_r <= pick;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------

    // The output-side maps of the full unit live in a separate block.
    // Each peripheral input lags its pin by one edge; a new selector
    // takes effect one edge after the write has landed.
    assign rdata_o = rdata_r;
    assign ext_irq_one_o = periph_r[S_IRQ1];
    assign ext_irq_two_o = periph_r[S_IRQ2];
    assign ext_irq_three_o = periph_r[S_IRQ3];
    assign ext_irq_four_o = periph_r[S_IRQ4];
    assign tmr_two_clk_o = periph_r[S_TMR2];
    assign tmr_three_clk_o = periph_r[S_TMR3];
    assign tmr_four_clk_o = periph_r[S_TMR4];
    assign tmr_five_clk_o = periph_r[S_TMR5];
    assign capture_o = periph_r[NSEL-1:S_CAP1];
    assign pin_map_lock_o = lock_r;

endmodule

// file: psim_input_map_monitor.sv
`timescale 1ns/1ps
`include "psim_regs.vh"

// ----------------------------------------------------------------------
// Port checker for the input pin map
// ----------------------------------------------------------------------
module psim_input_map_monitor (
    input wire clk_i,                        // System clock
    input wire nrst_i,                       // Async reset, active low
    input wire [`PSIM_ADDR_W-1:0] addr_i,    // Register word address
    input wire [`PSIM_DATA_W-1:0] wdata_i,   // Register write data
    input wire wr_i,                         // Write strobe
    input wire rd_i,                         // Read strobe
    input wire [`PSIM_DATA_W-1:0] rdata_o,   // Read data
    input wire [`PSIM_NUM_PINS-1:0] pins_i,  // Remappable pin levels
    input wire ext_irq_one_o,                // External interrupt 1 in
    input wire pin_map_lock_o                // Current lock state
);
    reg [5:0] sel_q; // Shadow of the irq1 selector
    reg exp_q;       // Expected irq1 level
    reg key_q;       // Last cycle wrote oscillator control
    reg bit_q;       // Lock bit carried by that write

    default clocking mon_cb @(posedge clk_i);
    endclocking
    default disable iff (!nrst_i);

    // Shadow follows unlocked writes only, so a leaky lock shows up
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sel_q <= `PSIM_SEL_RST;
            exp_q <= 1'b0;
            key_q <= 1'b0;
            bit_q <= 1'b0;
        end else begin
            exp_q <= (sel_q <= `PSIM_PIN_MAX) ? pins_i[sel_q] : 1'b0;
            key_q <= wr_i && (addr_i == `PSIM_ADDR_OSC_CTRL);
            bit_q <= wdata_i[`PSIM_LOCK_BIT];
            if (wr_i && addr_i == `PSIM_ADDR_IRQ1 && !pin_map_lock_o) begin
                sel_q <= wdata_i[13:8];
            end
        end
    end

    a_rdata_quiet: assert property (!rd_i |=> rdata_o == 16'h0000)
        else $error("read data seen without a read");
    a_unused_zero: assert property (
        rd_i && addr_i != `PSIM_ADDR_OSC_CTRL
        |=> rdata_o[15:14] == 2'b00 && rdata_o[7:6] == 2'b00)
        else $error("unused map bits read nonzero");
    a_irq1_low: assert property (rd_i && addr_i == `PSIM_ADDR_IRQ1
        |=> rdata_o[7:0] == 8'h00) else $error("irq1 map low byte nonzero");
    a_irq4_high: assert property (rd_i && addr_i == `PSIM_ADDR_IRQ4
        |=> rdata_o[15:6] == 10'h0) else $error("irq4 map high bits set");
    a_lock_keys: assert property ($changed(pin_map_lock_o)
        |-> key_q && bit_q == pin_map_lock_o)
        else $error("lock moved without a control write");
    a_lock_read: assert property (
        rd_i && addr_i == `PSIM_ADDR_OSC_CTRL
        |=> rdata_o == {9'h0, pin_map_lock_o, 6'h00})
        else $error("control read does not show the lock");
    a_irq1_route: assert property (ext_irq_one_o == exp_q)
        else $error("irq1 input does not follow its pin");
    a_unset_ground: assert property ($past(sel_q) == 6'h3F
        |-> !ext_irq_one_o) else $error("unset selector not grounded");
    // A write to the irq1 map may make the selector valid next cycle
    a_invalid_pin: assert property (
        sel_q > `PSIM_PIN_MAX && !(wr_i && addr_i == `PSIM_ADDR_IRQ1)
        |=> !ext_irq_one_o [*2]) else $error("invalid pin reached irq1");

    c_lock_set: cover property ($rose(pin_map_lock_o));
    c_lock_clear: cover property ($fell(pin_map_lock_o));
    c_irq1_high: cover property (ext_irq_one_o && sel_q <= `PSIM_PIN_MAX);
    c_bad_pin: cover property (sel_q > `PSIM_PIN_MAX && sel_q != 6'h3F);
endmodule

// file: psim_pin_model.sv
`timescale 1ns/1ps
`include "psim_regs.vh"

// ----------------------------------------------------------------------
// Remappable pads as seen from the map: levels settle after an edge
// ----------------------------------------------------------------------
module psim_pin_model (
    input wire clk_i,                       // System clock
    input wire [`PSIM_NUM_PINS-1:0] level_i, // Levels asked by the bench
    output reg [`PSIM_NUM_PINS-1:0] pins_o   // Levels at the pads
);
    // A change lands one edge late like a synchroniser; the bench asks
    // for idle-high pads, which appear at the first edge of reset
    always @(posedge clk_i) begin
        pins_o <= level_i;
    end
endmodule

// file: psim_pin_pick.v
`timescale 1ns/1ps
`include "psim_regs.vh"

// ----------------------------------------------------------------------
// One selector: picks a remappable pin by number, ground when invalid
// ----------------------------------------------------------------------
module psim_pin_pick (
    input wire [`PSIM_SEL_W-1:0] sel_i,     // Pin number selector
    input wire [`PSIM_NUM_PINS-1:0] pins_i, // All remappable pins
    output reg pick_o                       // Selected pin level
);

    // Numbers above the last pin, 63 included, give a grounded input
    always @* begin
        if (sel_i <= `PSIM_PIN_MAX) begin
            pick_o = pins_i[sel_i];
        end else begin
            pick_o = 1'b0;
        end
    end

endmodule

// file: psim_regs.vh
`ifndef PSIM_REGS_VH
`define PSIM_REGS_VH

// ----------------------------------------------------------------------
// Register addresses (word index on the register port)
// ----------------------------------------------------------------------
`define PSIM_ADDR_W 6
`define PSIM_DATA_W 16
`define PSIM_ADDR_IRQ1 6'h00
`define PSIM_ADDR_IRQ3_IRQ2 6'h01
`define PSIM_ADDR_IRQ4 6'h02
`define PSIM_ADDR_TMR3_TMR2 6'h03
`define PSIM_ADDR_TMR5_TMR4 6'h04
`define PSIM_ADDR_CAP2_CAP1 6'h07
`define PSIM_ADDR_CAP4_CAP3 6'h08
`define PSIM_ADDR_CAP6_CAP5 6'h09
`define PSIM_ADDR_CAP8_CAP7 6'h0A
`define PSIM_ADDR_OSC_CTRL 6'h20

// ----------------------------------------------------------------------
// Field layout
// ----------------------------------------------------------------------
`define PSIM_SEL_W 6
`define PSIM_SEL_HI_LSB 8
`define PSIM_SEL_LO_LSB 0
`define PSIM_LOCK_BIT 6
`define PSIM_NUM_SEL 16

// ----------------------------------------------------------------------
// Reset values and constants
// ----------------------------------------------------------------------
`define PSIM_SEL_RST 6'h3F
`define PSIM_LOCK_RST 1'b0
`define PSIM_KEY_FIRST 8'h46
`define PSIM_KEY_SECOND 8'h57
`define PSIM_PIN_MAX 6'h2B
`define PSIM_NUM_PINS 44

`endif

// file: tb.sv
`timescale 1ns/1ps
`include "psim_regs.vh"

module tb;
    // ------------------------------------------------------------------
    // Stimulus and observation
    // ------------------------------------------------------------------
    reg clk_i = 1'b0;
    reg nrst_i = 1'b0;
    reg [5:0] addr_i = 6'h00;
    reg [15:0] wdata_i = 16'h0000;
    reg wr_i = 1'b0;
    reg rd_i = 1'b0;
    reg [43:0] level = {44{1'b1}}; // Pad levels asked of the model
    wire [43:0] pins;
    wire [15:0] rdata_o;
    wire [15:0] outs; // Slot 0 irq1 .. 3 irq4, 4..7 timers, 8..15 captures
    wire lock;
    integer n_fail = 0;
    integer tests_run = 0;
    integer i;

    always #2.5 clk_i = ~clk_i;

    psim_pin_model u_pins (.clk_i(clk_i), .level_i(level), .pins_o(pins));

    psim_input_map u_dut (
        .clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pins_i(pins),
        .ext_irq_one_o(outs[0]), .ext_irq_two_o(outs[1]),
        .ext_irq_three_o(outs[2]), .ext_irq_four_o(outs[3]),
        .tmr_two_clk_o(outs[4]), .tmr_three_clk_o(outs[5]),
        .tmr_four_clk_o(outs[6]), .tmr_five_clk_o(outs[7]),
        .capture_o(outs[15:8]), .pin_map_lock_o(lock)
    );

    // ------------------------------------------------------------------
    // Register table helpers, map j = 0..8
    // ------------------------------------------------------------------
    function [5:0] adr(input integer j);
        adr = (j < 5) ? j[5:0] : j[5:0] + 6'h02; // Index 5 and 6 absent
    endfunction
    function [15:0] msk(input integer j);
        msk = (j == 0) ? 16'h3F00 : (j == 2) ? 16'h003F : 16'h3F3F;
    endfunction
    // Slot s uses pin 2s+3, so neighbours never share a pin
    function [5:0] pin_of(input integer s);
        pin_of = 6'h03 + {s[4:0], 1'b0};
    endfunction
    function [15:0] map_word(input integer j);
        integer h, l;
        begin
            h = (j == 0) ? 0 : (j == 1) ? 2 : (j == 2) ? 16 : 2 * j - 1;
            l = (j == 0) ? 16 : (j == 1) ? 1 : (j == 2) ? 3 : 2 * j - 2;
            map_word = {2'b11, pin_of(h), 2'b11, pin_of(l)};
        end
    endfunction
    function [15:0] route(input [43:0] lv);
        integer s;
        for (s = 0; s < 16; s = s + 1) begin
            route[s] = lv[pin_of(s)];
        end
    endfunction

    // ------------------------------------------------------------------
    // Bus tasks; the write strobe stays up across back-to-back writes, reads drop theirs
    // ------------------------------------------------------------------
    task chk(input [8*5-1:0] what, input [15:0] exp, input [15:0] got);
        begin
            tests_run = tests_run + 1;
            if (got !== exp) begin
                n_fail = n_fail + 1;
                $display("ERROR %0s expected %h seen %h", what, exp, got);
            end
        end
    endtask
    task bus_wr(input [5:0] a, input [15:0] d);
        begin
            addr_i <= a;
            wdata_i <= d;
            rd_i <= 1'b0;
            wr_i <= 1'b1;
            @(posedge clk_i);
        end
    endtask
    // Data stands only in the cycle after the strobe, so look mid-cycle
    task bus_rd(input [5:0] a, input [15:0] exp);
        begin
            addr_i <= a;
            wr_i <= 1'b0;
            rd_i <= 1'b1;
            @(posedge clk_i);
            rd_i <= 1'b0;
            @(negedge clk_i);
            chk("rdata", exp, rdata_o);
            @(posedge clk_i);
        end
    endtask
    // Pads land one edge late, outputs one more; four edges is ample
    task pin_chk(input [43:0] lv, input [15:0] exp);
        begin
            wr_i <= 1'b0;
            rd_i <= 1'b0;
            level <= lv;
            repeat (4) @(posedge clk_i);
            @(negedge clk_i);
            chk("outs", exp, outs);
            @(posedge clk_i);
        end
    endtask
    task complete_run;
        begin
            if (n_fail == 0 && tests_run > 0) begin
                $display("Testbench passed");
            end else begin
                $display("Testbench failed");
            end
            $finish;
        end
    endtask

    // Cuts a hang short
    initial begin
        repeat (5000) @(posedge clk_i);
        n_fail = n_fail + 1;
        complete_run;
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (8) @(posedge clk_i);
        nrst_i <= 1'b1;
        @(posedge clk_i);
        for (i = 0; i < 9; i = i + 1) bus_rd(adr(i), msk(i));
        bus_rd(`PSIM_ADDR_OSC_CTRL, 16'h0000);
        pin_chk({44{1'b1}}, 16'h0000);
        // Fields go to zero so a lost write differs from the reset value
        for (i = 0; i < 9; i = i + 1) begin
            bus_wr(adr(i), 16'hC0C0);
            bus_rd(adr(i), 16'h0000);
        end
        for (i = 0; i < 9; i = i + 1) bus_wr(adr(i), map_word(i));
        for (i = 0; i < 9; i = i + 1) begin
            bus_rd(adr(i),
                   map_word(i) & msk(i));
        end
        pin_chk(44'hA5A_C3C3_5AA5, route(44'hA5A_C3C3_5AA5));
        pin_chk(44'h5A5_3C3C_A55A, route(44'h5A5_3C3C_A55A));
        bus_wr(6'h05, 16'h1234);
        bus_rd(6'h05, 16'h0000);
        bus_wr(`PSIM_ADDR_IRQ1, 16'h2C00);
        pin_chk({44{1'b1}}, 16'hFFFE);
        bus_wr(`PSIM_ADDR_IRQ1, 16'h2B00);
        pin_chk({44{1'b1}}, 16'hFFFF);
        bus_wr(`PSIM_ADDR_OSC_CTRL, 16'h0046);
        bus_rd(`PSIM_ADDR_IRQ1, 16'h2B00);
        bus_wr(`PSIM_ADDR_OSC_CTRL, 16'h0057);
        bus_wr(`PSIM_ADDR_OSC_CTRL, 16'h00C0);
        bus_rd(`PSIM_ADDR_OSC_CTRL, 16'h0040);
        chk("lock", 16'h0001, {15'h0, lock});
        bus_wr(`PSIM_ADDR_IRQ1, 16'h0500);
        bus_rd(`PSIM_ADDR_IRQ1, 16'h2B00);
        bus_wr(`PSIM_ADDR_OSC_CTRL, 16'h0046);
        bus_wr(`PSIM_ADDR_OSC_CTRL, 16'h0058);
        bus_wr(`PSIM_ADDR_OSC_CTRL, 16'h0000);
        bus_rd(`PSIM_ADDR_OSC_CTRL, 16'h0040);
        bus_wr(`PSIM_ADDR_OSC_CTRL, 16'h0046);
        bus_wr(`PSIM_ADDR_IRQ4, 16'h0001);
        bus_wr(`PSIM_ADDR_OSC_CTRL, 16'h0057);
        bus_wr(`PSIM_ADDR_OSC_CTRL, 16'h0000);
        bus_rd(`PSIM_ADDR_OSC_CTRL, 16'h0040);
        // A repeated first key restarts the sequence
        bus_wr(`PSIM_ADDR_OSC_CTRL, 16'h0046);
        bus_wr(`PSIM_ADDR_OSC_CTRL, 16'h0046);
        bus_wr(`PSIM_ADDR_OSC_CTRL, 16'h0057);
        bus_wr(`PSIM_ADDR_OSC_CTRL, 16'h0000);
        bus_wr(`PSIM_ADDR_IRQ1, 16'h0500);
        chk("lock", 16'h0000, {15'h0, lock});
        bus_rd(`PSIM_ADDR_IRQ1, 16'h0500);
        nrst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        nrst_i <= 1'b1;
        @(posedge clk_i);
        bus_rd(`PSIM_ADDR_IRQ1, 16'h3F00);
        complete_run;
    end
endmodule

bind psim_input_map psim_input_map_monitor u_mon (
    .clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pins_i(pins_i),
    .ext_irq_one_o(ext_irq_one_o), .pin_map_lock_o(pin_map_lock_o)
);
